//--- fwsr_pkg.sv
// shared constants and types for the flash write-status host controller
package fwsr_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ     = 25;
  localparam int unsigned STROBE_NS   = 50;   // strobe low time per flash cycle
  localparam int unsigned RECOVER_NS  = 30;   // strobe high time before chip enable lifts
  localparam int unsigned STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_RDATA  = 8'h10;
  // control fields
  localparam int unsigned CTRL_GO    = 0;
  localparam int unsigned CTRL_ABORT = 1;
  localparam int unsigned CTRL_OP    = 4;
  // status fields
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_DONE   = 1;
  localparam int unsigned ST_FAIL   = 2;
  localparam int unsigned ST_REJECT = 3;
  localparam int unsigned ST_RDY    = 4;
  // flash status bit positions
  localparam int unsigned TOG1_POS = 6;
  localparam int unsigned FAIL_POS = 5;
  localparam int unsigned WIN_POS  = 3;
  // reset values
  localparam logic [19:0] ADDR_RST  = 20'h00000;
  localparam logic [15:0] WDATA_RST = 16'h0000;
  // command cycle addresses and data
  localparam logic [19:0] UNLOCK_A1 = 20'h00555;
  localparam logic [19:0] UNLOCK_A2 = 20'h002aa;
  localparam logic [15:0] CD_AA = 16'h00aa;
  localparam logic [15:0] CD_55 = 16'h0055;
  localparam logic [15:0] CD_PROG = 16'h00a0;
  localparam logic [15:0] CD_ERASE = 16'h0080;
  localparam logic [15:0] CD_CHIP = 16'h0010;
  localparam logic [15:0] CD_SECT = 16'h0030;
  localparam logic [15:0] CD_SUSP = 16'h00b0;
  localparam logic [15:0] CD_RESUME = 16'h0030;
  localparam logic [15:0] CD_RESET = 16'h00f0;
  // operations software may order
  typedef enum logic [2:0] {
    OP_PROG, OP_SERASE, OP_CERASE, OP_ADDSEC, OP_SUSPEND, OP_RESUME, OP_RESET, OP_POLL
  } fwsr_op_type;
endpackage

//--- fwsr_bus_cycle.sv
// single flash bus cycle engine: one write or one read per start pulse
`timescale 1ns/10ps
module fwsr_bus_cycle #(
  parameter int unsigned AW = 20,
  parameter int unsigned DW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // request side
  input  wire logic          start,
  input  wire logic          isWrite,
  input  wire logic [AW-1:0] cycAddr,
  input  wire logic [DW-1:0] cycWdata,
  output logic               cycDone,
  output logic [DW-1:0]      cycRdata,
  // flash pins
  output logic               ceN,
  output logic               oeN,
  output logic               weN,
  output logic [AW-1:0]      flAddr,
  output logic [DW-1:0]      dqOut,
  output logic               dqOeN,
  input  wire logic [DW-1:0] dqIn
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fwsr_cyc_type;

  fwsr_cyc_type    st_q, st_d;       // cycle phase
  logic [3:0]      cnt_q, cnt_d;     // phase counter
  logic            wr_q, wr_d;       // direction of current cycle
  logic            ce_q, ce_d, oe_q, oe_d, we_q, we_d, dqoe_q, dqoe_d;
  logic [AW-1:0]   a_q, a_d;
  logic [DW-1:0]   w_q, w_d, r_q, r_d;
  logic            dn_q, dn_d;

  // next phase and pin values
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; wr_d = wr_q; a_d = a_q; w_d = w_q; r_d = r_q;
    ce_d = ce_q; oe_d = oe_q; we_d = we_q; dqoe_d = dqoe_q; dn_d = 1'b0;
    unique case (st_q)
      C_IDLE: if (start) begin
        // address and data settle one cycle ahead of the strobe
        st_d = C_SETUP; wr_d = isWrite; a_d = cycAddr; w_d = cycWdata;
        ce_d = 1'b0; dqoe_d = ~isWrite;
      end
      C_SETUP: begin
        st_d = C_STROBE; cnt_d = 4'(fwsr_pkg::STROBE_CYC - 1);
        we_d = ~wr_q; oe_d = wr_q;
      end
      C_STROBE: if (cnt_q == 4'h0) begin
        // read data is taken while output enable is still low
        if (!wr_q) r_d = dqIn;
        we_d = 1'b1; oe_d = 1'b1; st_d = C_HOLD;
        cnt_d = 4'(fwsr_pkg::RECOVER_CYC - 1);
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      C_HOLD: if (cnt_q == 4'h0) begin
        ce_d = 1'b1; dqoe_d = 1'b1; dn_d = 1'b1; st_d = C_IDLE;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
    endcase
  end

  // register phase and pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= C_IDLE; cnt_q <= 4'h0; wr_q <= 1'b0; a_q <= '0; w_q <= '0; r_q <= '0;
      ce_q <= 1'b1; oe_q <= 1'b1; we_q <= 1'b1; dqoe_q <= 1'b1; dn_q <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; wr_q <= wr_d; a_q <= a_d; w_q <= w_d; r_q <= r_d;
      ce_q <= ce_d; oe_q <= oe_d; we_q <= we_d; dqoe_q <= dqoe_d; dn_q <= dn_d;
    end
  end

  assign ceN = ce_q;
  assign oeN = oe_q;
  assign weN = we_q;
  assign flAddr = a_q;
  assign dqOut = w_q;
  assign dqOeN = dqoe_q;
  assign cycRdata = r_q;
  assign cycDone = dn_q;
endmodule // fwsr_bus_cycle

//--- fwsr_host.sv
// host controller: apb registers, flash command sequences, toggle-bit polling
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
module fwsr_host #(
  parameter int unsigned AW = 20,
  parameter int unsigned DW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // flash pins
  output logic               ceN,
  output logic               oeN,
  output logic               weN,
  output logic [AW-1:0]      flAddr,
  output logic [DW-1:0]      dqOut,
  output logic               dqOeN,
  input  wire logic [DW-1:0] dqIn,
  input  wire logic          readyBusyN
);
  typedef enum logic [3:0] {
    S_IDLE, S_PRE, S_SEQ, S_POLL_A, S_POLL_B, S_EVAL, S_CHK_A, S_CHK_B, S_CHK_EVAL, S_RST_CMD
  } fwsr_state_type;

  fwsr_state_type         st_q, st_d;          // sequencer state
  fwsr_pkg::fwsr_op_type  op_q, op_d;          // operation in progress
  logic [2:0]             idx_q, idx_d;        // command cycle index
  logic                   iss_q, iss_d;        // bus cycle issued, awaiting done
  logic [AW-1:0]          addr_q, addr_d;      // target address register
  logic [DW-1:0]          wdat_q, wdat_d;      // program data register
  logic [DW-1:0]          rdA_q, rdA_d;        // first read of a pair
  logic [DW-1:0]          rdB_q, rdB_d;        // second read of a pair
  logic                   done_q, done_d;      // sticky completion
  logic                   fail_q, fail_d;      // sticky failure
  logic                   rej_q, rej_d;        // added sector may be rejected
  logic                   abort_q, abort_d;    // software stop request
  logic                   rdy_q;               // sampled ready/busy pin
  logic                   pready_q, pready_d;
  logic [31:0]            prdata_q, prdata_d;
  logic                   perr_q, perr_d;
  // bus cycle engine hookup
  logic                   cStart, cWrite, cDone;
  logic [AW-1:0]          cAddr;
  logic [DW-1:0]          cWdata, cRdata;
  // command table lookup
  logic [AW-1:0]          sAddr;
  logic [DW-1:0]          sData;
  logic                   sLast;
  logic                   apbWr;
  logic                   goWr;

  assign apbWr = psel && penable && pready_q && pwrite;
  assign goWr  = apbWr && paddr == fwsr_pkg::OFF_CTRL && pwdata[fwsr_pkg::CTRL_GO];

  // command sequence table: address and data of cycle idx for op
  always_comb begin
    sAddr = fwsr_pkg::UNLOCK_A1;
    sData = fwsr_pkg::CD_AA;
    sLast = 1'b0;
    unique case (op_q)
      fwsr_pkg::OP_PROG, fwsr_pkg::OP_SERASE, fwsr_pkg::OP_CERASE: begin
        unique case (idx_q)
          3'h0: ;
          3'h1: begin sAddr = fwsr_pkg::UNLOCK_A2; sData = fwsr_pkg::CD_55; end
          3'h2: sData = (op_q == fwsr_pkg::OP_PROG) ? fwsr_pkg::CD_PROG : fwsr_pkg::CD_ERASE;
          3'h3: if (op_q == fwsr_pkg::OP_PROG) begin
            // program ends on the data cycle at the target
            sAddr = addr_q; sData = wdat_q; sLast = 1'b1;
          end
          3'h4: begin sAddr = fwsr_pkg::UNLOCK_A2; sData = fwsr_pkg::CD_55; end
          default: begin
            sLast = 1'b1;
            if (op_q == fwsr_pkg::OP_CERASE) begin
              sData = fwsr_pkg::CD_CHIP;
            end else begin
              sAddr = addr_q; sData = fwsr_pkg::CD_SECT;
            end
          end
        endcase
      end
      fwsr_pkg::OP_ADDSEC: begin sAddr = addr_q; sData = fwsr_pkg::CD_SECT; sLast = 1'b1; end
      fwsr_pkg::OP_SUSPEND: begin sData = fwsr_pkg::CD_SUSP; sLast = 1'b1; end
      fwsr_pkg::OP_RESUME: begin sData = fwsr_pkg::CD_RESUME; sLast = 1'b1; end
      default: begin sData = fwsr_pkg::CD_RESET; sLast = 1'b1; end
    endcase
  end

  // sequencer and register writes
  always_comb begin
    st_d = st_q; op_d = op_q; idx_d = idx_q; iss_d = iss_q;
    addr_d = addr_q; wdat_d = wdat_q; rdA_d = rdA_q; rdB_d = rdB_q;
    done_d = done_q; fail_d = fail_q; rej_d = rej_q; abort_d = abort_q;
    cStart = 1'b0; cWrite = 1'b0; cAddr = addr_q; cWdata = sData;
    if (apbWr && paddr == fwsr_pkg::OFF_ADDR) addr_d = pwdata[AW-1:0];
    if (apbWr && paddr == fwsr_pkg::OFF_WDATA) wdat_d = pwdata[DW-1:0];
    // stop request is latched in any busy state; only the poll states act on it
    if (apbWr && paddr == fwsr_pkg::OFF_CTRL && pwdata[fwsr_pkg::CTRL_ABORT] && st_q != S_IDLE) abort_d = 1'b1;
    // every read and write goes through one issue/wait slot
    if (st_q != S_IDLE && st_q != S_EVAL && st_q != S_CHK_EVAL && !iss_q) begin
      cStart = 1'b1; iss_d = 1'b1;
    end
    if (cDone) iss_d = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        abort_d = 1'b0;
        cStart = 1'b0; iss_d = 1'b0;
        if (goWr) begin
          op_d = fwsr_pkg::fwsr_op_type'(pwdata[fwsr_pkg::CTRL_OP +: 3]);
          idx_d = 3'h0; done_d = 1'b0; fail_d = 1'b0; rej_d = 1'b0;
          if (op_d == fwsr_pkg::OP_POLL) st_d = S_POLL_A;   // fresh double read
          else if (op_d == fwsr_pkg::OP_ADDSEC) st_d = S_PRE;  // window check first
          else st_d = S_SEQ;
        end
      end
      S_PRE: if (cDone) begin
        // window already closed before the add (WIN_POS bit set): the add may be ignored
        // always checked, since spacing of added sectors is up to software
        rej_d = cRdata[fwsr_pkg::WIN_POS];
        st_d = S_SEQ;
      end
      S_SEQ: begin
        cWrite = 1'b1; cAddr = sAddr;
        if (cDone) begin
          idx_d = idx_q + 3'h1;
          if (sLast) begin
            if (op_q == fwsr_pkg::OP_RESET || op_q == fwsr_pkg::OP_SUSPEND || op_q == fwsr_pkg::OP_RESUME) begin
              st_d = S_IDLE; done_d = 1'b1;
            end else begin
              st_d = S_POLL_A;
            end
          end
        end
      end
      S_POLL_A: if (cDone) begin
        rdA_d = cRdata;
        // second window check, right after the added sector command
        if (op_q == fwsr_pkg::OP_ADDSEC && idx_q != 3'h0) begin
          rej_d = rej_q | cRdata[fwsr_pkg::WIN_POS];
          idx_d = 3'h0;
        end
        st_d = abort_q ? S_IDLE : S_POLL_B;
      end
      S_POLL_B: if (cDone) begin
        rdB_d = cRdata;
        st_d = S_EVAL;
      end
      S_EVAL: begin
        if (abort_q) st_d = S_IDLE;
        else if (rdA_q[fwsr_pkg::TOG1_POS] == rdB_q[fwsr_pkg::TOG1_POS]) begin
          st_d = S_IDLE; done_d = 1'b1;
        end else if (rdB_q[fwsr_pkg::FAIL_POS]) st_d = S_CHK_A;
        else st_d = S_POLL_A;
      end
      S_CHK_A: if (cDone) begin
        rdA_d = cRdata; st_d = S_CHK_B;
      end
      S_CHK_B: if (cDone) begin
        rdB_d = cRdata; st_d = S_CHK_EVAL;
      end
      S_CHK_EVAL: begin
        // toggle may have stopped just as the fail bit rose
        if (rdA_q[fwsr_pkg::TOG1_POS] == rdB_q[fwsr_pkg::TOG1_POS]) begin
          st_d = S_IDLE; done_d = 1'b1;
        end else begin
          st_d = S_RST_CMD;
        end
      end
      S_RST_CMD: begin
        cWrite = 1'b1; cAddr = fwsr_pkg::UNLOCK_A1; cWdata = fwsr_pkg::CD_RESET;
        if (cDone) begin
          st_d = S_IDLE; done_d = 1'b1; fail_d = 1'b1;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // apb answer, registered: one access cycle, no wait
  always_comb begin
    pready_d = psel && !penable;
    perr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        fwsr_pkg::OFF_CTRL: prdata_d = {25'h0, op_q, 4'h0};
        fwsr_pkg::OFF_ADDR: prdata_d = 32'(addr_q);
        fwsr_pkg::OFF_WDATA: prdata_d = 32'(wdat_q);
        fwsr_pkg::OFF_STATUS: prdata_d = {27'h0, rdy_q, rej_q, fail_q, done_q, st_q != S_IDLE};
        fwsr_pkg::OFF_RDATA: prdata_d = 32'(rdB_q);
        default: perr_d = 1'b1;  // unmapped
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE; op_q <= fwsr_pkg::OP_PROG; idx_q <= 3'h0; iss_q <= 1'b0;
      addr_q <= fwsr_pkg::ADDR_RST; wdat_q <= fwsr_pkg::WDATA_RST;
      rdA_q <= '0; rdB_q <= '0; done_q <= 1'b0; fail_q <= 1'b0; rej_q <= 1'b0;
      abort_q <= 1'b0; rdy_q <= 1'b1;
      pready_q <= 1'b0; prdata_q <= 32'h0000_0000; perr_q <= 1'b0;
    end else begin
      st_q <= st_d; op_q <= op_d; idx_q <= idx_d; iss_q <= iss_d;
      addr_q <= addr_d; wdat_q <= wdat_d;
      rdA_q <= rdA_d; rdB_q <= rdB_d; done_q <= done_d; fail_q <= fail_d; rej_q <= rej_d;
      abort_q <= abort_d; rdy_q <= readyBusyN;
      pready_q <= pready_d; prdata_q <= prdata_d; perr_q <= perr_d;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = perr_q;

  // one flash cycle at a time
  fwsr_bus_cycle #(.AW(AW), .DW(DW)) u_cyc (
    .clk(clk), .rst(rst), .start(cStart), .isWrite(cWrite), .cycAddr(cAddr),
    .cycWdata(cWdata), .cycDone(cDone), .cycRdata(cRdata), .ceN(ceN), .oeN(oeN),
    .weN(weN), .flAddr(flAddr), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn)
  );

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  stop_when_steady_a: assert property (
    st_q == S_EVAL && !abort_q && rdA_q[6] == rdB_q[6] |=> st_q == S_IDLE && done_q && !fail_q)
    else $error("steady toggle did not finish");
  keep_polling_a: assert property (
    st_q == S_EVAL && !abort_q && rdA_q[6] != rdB_q[6] && !rdB_q[5] |=> st_q == S_POLL_A)
    else $error("toggling without fail bit did not reread");
  fail_recheck_a: assert property (
    st_q == S_EVAL && !abort_q && rdA_q[6] != rdB_q[6] && rdB_q[5] |=> st_q == S_CHK_A)
    else $error("fail bit seen without recheck");
  recheck_fail_a: assert property (
    st_q == S_CHK_EVAL && rdA_q[6] != rdB_q[6] |=> st_q == S_RST_CMD ##[1:40] (!weN && dqOut == 16'h00f0))
    else $error("still toggling but no reset command");
  reset_marks_fail_a: assert property (
    st_q == S_RST_CMD && cDone |=> fail_q && done_q && st_q == S_IDLE)
    else $error("reset command did not end as failure");
  poll_restart_a: assert property (
    st_q == S_IDLE && goWr && pwdata[6:4] == 3'h7 |=> st_q == S_POLL_A ##1 !ceN)
    else $error("poll did not restart with a double read");
  poll_address_a: assert property (
    cStart && !cWrite && st_q != S_PRE |=> ##1 flAddr == addr_q)
    else $error("status read not at target address");
  window_check_a: assert property (
    st_q == S_SEQ && op_q == fwsr_pkg::OP_ADDSEC |-> $past(st_q, 1) inside {S_PRE, S_SEQ})
    else $error("added sector written without prior window check");
  apb_onecycle_a: assert property (
    psel && !penable |=> pready && (pslverr == !($past(paddr) inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})))
    else $error("apb answer wrong");

  prog_done_c: cover property (st_q == S_SEQ && op_q == fwsr_pkg::OP_PROG ##[1:1000] st_q == S_IDLE && done_q);
  fail_path_c: cover property (st_q == S_RST_CMD);
  reject_seen_c: cover property (rej_q && st_q == S_IDLE);
  abort_c: cover property (abort_q && st_q == S_IDLE);
endmodule // fwsr_host

//--- fwsr_flash_model.sv
// behavioural flash device answering the host's command and status cycles
`timescale 1ns/10ps
module fwsr_flash_model #(
  parameter int unsigned PROG_RD   = 3,    // status reads a program lasts
  parameter int unsigned ERASE_RD  = 40,   // status reads an erase lasts
  parameter int unsigned WIN_RD    = 8,    // reads of the sector acceptance window
  parameter logic [7:0]  PROT_SECT = 8'h02 // the one protected sector
) (
  // flash pins
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [19:0] flAddr,
  input  wire logic [15:0] dqOut,
  input  wire logic        dqOeN,
  // device answers
  output logic [15:0]      dqIn,
  output logic             readyBusyN
);
  typedef enum logic [1:0] {M_IDLE, M_PROG, M_ERASE, M_SUSP} fwsr_mode_type;
  fwsr_mode_type   mode     = M_IDLE; // embedded algorithm state
  logic [15:0]     mem [logic [19:0]]; // written words, the rest read all ones
  logic [255:0]    eraseSet = '0;     // sectors picked for erasure
  logic [19:0]     pAddr    = 20'h00000;
  logic [15:0]     pData    = 16'h0000;
  logic [15:0]     rdVal    = 16'h0000;
  logic [2:0]      seq      = 3'h0;   // unlock sequence position
  logic            tog1     = 1'b0;
  logic            tog2     = 1'b0;
  logic            failBit  = 1'b0;
  logic            bad      = 1'b0;   // program tried to raise a zero bit
  int              left     = 0;
  int              win      = 0;
  wire             rdEn     = !ceN && !oeN; // read only while both enables are low
  function automatic logic [15:0] arr(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // no pull on the data lines: once released they show the inverse of the last word
  assign dqIn = rdEn ? rdVal : ~rdVal;
  // open drain with pull-up: low only while an algorithm runs
  assign readyBusyN = !(mode == M_PROG || mode == M_ERASE);
  // end of an algorithm: protected places stay untouched
  task automatic finish();
    if (mode == M_PROG && pAddr[19:12] != PROT_SECT)
      mem[pAddr] = pData;
    if (mode == M_ERASE)
      foreach (mem[k])
        if (eraseSet[k[19:12]] && k[19:12] != PROT_SECT)
          mem[k] = 16'hffff;
    mode = M_IDLE;
  endtask
  // each read start: status while busy or in a suspended erase sector, array data otherwise
  always @(posedge rdEn) begin
    if (mode == M_PROG || mode == M_ERASE) begin
      tog1 = ~tog1;
      if (mode == M_ERASE && eraseSet[flAddr[19:12]])
        tog2 = ~tog2;
      rdVal = {8'h00, (mode == M_PROG) ? ~pData[7] : 1'b0, tog1, failBit, 1'b0, win == 0, tog2, 2'b00};
      if (win > 0)
        win--;
      else if (left > 0)
        left--;
      else if (bad)
        failBit = 1'b1;
      else
        finish();
    end else if (mode == M_SUSP && eraseSet[flAddr[19:12]]) begin
      tog2 = ~tog2;
      rdVal = {8'h00, 1'b1, tog1, 4'h0, tog2, 2'b00};
    end else
      rdVal = arr(flAddr);
  end
  // command cycles latch at the end of the write strobe
  always @(posedge weN) begin
    if (!ceN && !dqOeN) begin
      if (dqOut[7:0] == 8'hf0) begin
        mode = M_IDLE;
        failBit = 1'b0;
        seq = 3'h0;
      end else if (mode == M_ERASE && dqOut[7:0] == 8'hb0) begin
        mode = M_SUSP;
        win = 0;
      end else if (mode == M_SUSP && dqOut[7:0] == 8'h30)
        mode = M_ERASE;
      else if (mode == M_ERASE && win > 0 && dqOut[7:0] == 8'h30) begin
        eraseSet[flAddr[19:12]] = 1'b1;
        win = WIN_RD;
      end else if (mode == M_IDLE) begin
        case (seq)
          3'h0: seq = (dqOut[7:0] == 8'haa) ? 3'h1 : 3'h0;
          3'h1, 3'h4: seq = (dqOut[7:0] == 8'h55) ? seq + 3'h1 : 3'h0;
          3'h2: seq = (dqOut[7:0] == 8'ha0) ? 3'h6 : (dqOut[7:0] == 8'h80) ? 3'h3 : 3'h0;
          3'h3: seq = (dqOut[7:0] == 8'haa) ? 3'h4 : 3'h0;
          3'h5: begin
            mode = M_ERASE;
            left = ERASE_RD;
            win = (dqOut[7:0] == 8'h30) ? WIN_RD : 0;
            eraseSet = (dqOut[7:0] == 8'h30) ? 256'h1 << flAddr[19:12] : '1;
            seq = 3'h0;
          end
          default: begin
            mode = M_PROG;
            pAddr = flAddr;
            pData = dqOut;
            bad = |(dqOut & ~arr(flAddr));
            left = PROG_RD;
            seq = 3'h0;
          end
        endcase
      end
    end
  end
endmodule // fwsr_flash_model

//--- tb.sv
// testbench: orders host operations over apb against the flash model
`timescale 1ns/10ps
module tb;
  logic        clk     = 1'b0; // 25 MHz
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, se, ceN, oeN, weN, dqOeN, readyBusyN;
  logic [19:0] flAddr;
  logic [15:0] dqOut, dqIn;
  int          errTotal = 0;
  int          checked  = 0;
  int          cyc      = 0;
  fwsr_host u_fwsr_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ceN(ceN),
    .oeN(oeN), .weN(weN), .flAddr(flAddr), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn),
    .readyBusyN(readyBusyN));
  fwsr_flash_model u_fwsr_flash_model (.ceN(ceN), .oeN(oeN), .weN(weN), .flAddr(flAddr),
    .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn), .readyBusyN(readyBusyN));
  // clock
  initial forever #20 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (errTotal == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer held until pready, result kept in rd and se
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read status until busy drops; the global timeout cuts a hang
  task automatic wait_idle();
    do apb(1'b0, fwsr_pkg::OFF_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic go(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
    apb(1'b1, fwsr_pkg::OFF_ADDR, {12'h000, a});
    apb(1'b1, fwsr_pkg::OFF_WDATA, {16'h0000, d});
    apb(1'b1, fwsr_pkg::OFF_CTRL, {25'h0, op, 4'h1});
  endtask
  task automatic run_op(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
    go(op, a, d);
    wait_idle();
  endtask
  // erase started, then its polling is abandoned so other orders can follow
  task automatic erase_abort(input logic [2:0] op, input logic [19:0] a);
    go(op, a, 16'h0000);
    apb(1'b1, fwsr_pkg::OFF_CTRL, {25'h0, op, 4'h2});
    wait_idle();
  endtask
  // hang guard, far above the thousand or so cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, fwsr_pkg::OFF_STATUS, 32'h0);
    check(rd, 32'h10);
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, se}, 32'h1); // unmapped place refused
    run_op(fwsr_pkg::OP_PROG, 20'h00100, 16'h1234);
    check(rd, 32'h12);
    apb(1'b0, fwsr_pkg::OFF_RDATA, 32'h0);
    check(rd, 32'h1234);
    check({16'h0, u_fwsr_flash_model.arr(20'h00100)}, 32'h1234);
    run_op(fwsr_pkg::OP_PROG, 20'h03000, 16'h0f0f);
    // raising zero bits must end in failure and a reset command
    run_op(fwsr_pkg::OP_PROG, 20'h00100, 16'h00ff);
    check(rd & 32'h14, 32'h14);
    check({31'h0, readyBusyN}, 32'h1);
    check({16'h0, u_fwsr_flash_model.arr(20'h00100)}, 32'h1234);
    // protected sector: toggles briefly, nothing written
    run_op(fwsr_pkg::OP_PROG, 20'h02010, 16'h5555);
    check(rd & 32'h6, 32'h2);
    check({16'h0, u_fwsr_flash_model.arr(20'h02010)}, 32'hffff);
    // sector erase, extra sector inside the window, suspend, resume
    // the add is left running so the suspend meets an erase still in progress
    erase_abort(fwsr_pkg::OP_SERASE, 20'h00100);
    erase_abort(fwsr_pkg::OP_ADDSEC, 20'h03000);
    check(rd & 32'h8, 32'h0);
    run_op(fwsr_pkg::OP_SUSPEND, 20'h00100, 16'h0);
    check(rd & 32'h11, 32'h10);
    run_op(fwsr_pkg::OP_POLL, 20'h00100, 16'h0);
    check(rd & 32'h3, 32'h2);
    apb(1'b0, fwsr_pkg::OFF_RDATA, 32'h0);
    check(rd & 32'h80, 32'h80);
    run_op(fwsr_pkg::OP_RESUME, 20'h00100, 16'h0);
    run_op(fwsr_pkg::OP_POLL, 20'h00100, 16'h0);
    check(rd & 32'h7, 32'h2);
    check({16'h0, u_fwsr_flash_model.arr(20'h00100)}, 32'hffff);
    check({16'h0, u_fwsr_flash_model.arr(20'h03000)}, 32'hffff);
    // chip erase has no window: an added sector is turned away
    erase_abort(fwsr_pkg::OP_CERASE, 20'h00000);
    run_op(fwsr_pkg::OP_ADDSEC, 20'h05000, 16'h0);
    check(rd & 32'h8, 32'h8);
    run_op(fwsr_pkg::OP_POLL, 20'h00000, 16'h0);
    check(rd & 32'h7, 32'h2);
    apb(1'b0, fwsr_pkg::OFF_CTRL, 32'h0);
    check({29'h0, rd[6:4]}, 32'h7);
    run_op(fwsr_pkg::OP_RESET, 20'h00000, 16'h0);
    check(rd & 32'h11, 32'h10);
    complete_run();
  end
endmodule // tb
